// [shared/gc_regs.svh]
// Register map, field positions, reset values and timing figures
// of the gated 16-bit counter. Definitions only; include by bare name.
`ifndef GC_REGS_SVH
`define GC_REGS_SVH

// -----------------------------------------------------------------
// Register offsets (3-bit address, 8-bit data)
// -----------------------------------------------------------------
`define GC_AW              3
`define GC_DW              8
`define GC_OFF_TCON        3'h0
`define GC_OFF_GCON        3'h1
`define GC_OFF_CNTL        3'h2
`define GC_OFF_CNTH        3'h3
`define GC_OFF_IFLG        3'h4
`define GC_OFF_IEN         3'h5
`define GC_OFF_ICTL        3'h6

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define GC_TC_CS_HI        7
`define GC_TC_CS_LO        6
`define GC_TC_PS_HI        5
`define GC_TC_PS_LO        4
`define GC_TC_SYNC         2
`define GC_TC_ON           0
`define GC_GC_GE           7
`define GC_GC_POL          6
`define GC_GC_TM           5
`define GC_GC_SPM          4
`define GC_GC_GO           3
`define GC_GC_GVAL         2
`define GC_GC_SS_HI        1
`define GC_GC_SS_LO        0
`define GC_IF_GATE         7
`define GC_IF_OVF          0
`define GC_IC_GIE          7
`define GC_IC_PERIPHERAL_IRQ_ENABLE         6

// -----------------------------------------------------------------
// Reset values and codes
// -----------------------------------------------------------------
`define GC_RST_BYTE        8'h00
`define GC_RST_COUNT       16'h0000
`define GC_COUNT_TOP       16'hffff
`define GC_CS_EXT          2'h2
`define GC_CLK_PERIOD_NS   40

`endif

// [shared/gc_pkg.sv]
// Types shared by the gated counter design.
// Assumes gc_regs.svh carries all numeric constants.
package gc_pkg;

   // Single-pulse acquisition progress
   typedef enum logic [1:0] {
      SP_IDLE,
      SP_WAIT,
      SP_OPEN
   } gc_sp_e;

   typedef logic [15:0] gc_count_t;

endpackage

// [hdl/gc_gated_counter.sv]
// Gate and interrupt logic of a 16-bit incrementing counter.
// Assumes a register master on core_clk; timer_clock, gate_pin and
// both comparator outputs are asynchronous; the byte-timer wrap
// pulse comes from logic already on core_clk.
`include "gc_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module gc_gated_counter
   import gc_pkg::*;
(
   input  wire logic                core_clk,
   input  wire logic                rst_b,
   input  wire logic [`GC_AW-1:0]   addr,
   input  wire logic [`GC_DW-1:0]   wr_data,
   input  wire logic                wr_stb,
   input  wire logic                rd_stb,
   output logic      [`GC_DW-1:0]   rd_data,
   input  wire logic                timer_clock,
   input  wire logic                gate_pin,
   input  wire logic                byte_timer_wrap_pulse,
   input  wire logic                comparator_a_output,
   input  wire logic                comparator_b_output,
   input  wire logic                sleep_mode,
   output logic                     irq_req,
   output logic                     wake_req
);

   // ----------------------------------------------------------------
   // Register write decode
   // ----------------------------------------------------------------

   // Write hit on one offset
   function automatic logic wr_hit(input logic            stb,
                                   input logic [`GC_AW-1:0] a,
                                   input logic [`GC_AW-1:0] off);
      wr_hit = stb && (a == off);
   endfunction

   logic wr_tcon;
   logic wr_gcon;
   logic wr_cntl;
   logic wr_cnth;
   logic wr_iflg;
   logic wr_ien;
   logic wr_ictl;
   logic wr_cnt;

   assign wr_tcon = wr_hit(wr_stb, addr, `GC_OFF_TCON);
   assign wr_gcon = wr_hit(wr_stb, addr, `GC_OFF_GCON);
   assign wr_cntl = wr_hit(wr_stb, addr, `GC_OFF_CNTL);
   assign wr_cnth = wr_hit(wr_stb, addr, `GC_OFF_CNTH);
   assign wr_iflg = wr_hit(wr_stb, addr, `GC_OFF_IFLG);
   assign wr_ien  = wr_hit(wr_stb, addr, `GC_OFF_IEN);
   assign wr_ictl = wr_hit(wr_stb, addr, `GC_OFF_ICTL);
   assign wr_cnt  = wr_cntl || wr_cnth;

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   logic [1:0] clock_source_select_r;
   logic [1:0] prescale_r;
   logic       sync_bypass_r;
   logic       timer_on_r;
   logic       gate_enable_bit_r;
   logic       gate_polarity_r;
   logic       gate_toggle_mode_r;
   logic       gate_single_pulse_mode_r;
   logic [1:0] gate_source_select_r;
   logic       gate_event_irq_enable_r;
   logic       overflow_irq_enable_r;
   logic       global_irq_enable_r;
   logic       peripheral_irq_enable_r;

   // Timer control; prescale is held for software only, the
   // divider sits outside this block
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         clock_source_select_r <= 2'h0;
         prescale_r            <= 2'h0;
         sync_bypass_r         <= 1'b0;
         timer_on_r            <= 1'b0;
      end else if (wr_tcon) begin
         clock_source_select_r <= wr_data[`GC_TC_CS_HI:`GC_TC_CS_LO];
         prescale_r            <= wr_data[`GC_TC_PS_HI:`GC_TC_PS_LO];
         sync_bypass_r         <= wr_data[`GC_TC_SYNC];
         timer_on_r            <= wr_data[`GC_TC_ON];
      end
   end

   // Gate control, all but the go and level bits
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         gate_enable_bit_r        <= 1'b0;
         gate_polarity_r          <= 1'b0;
         gate_toggle_mode_r       <= 1'b0;
         gate_single_pulse_mode_r <= 1'b0;
         gate_source_select_r     <= 2'h0;
      end else if (wr_gcon) begin
         gate_enable_bit_r        <= wr_data[`GC_GC_GE];
         gate_polarity_r          <= wr_data[`GC_GC_POL];
         gate_toggle_mode_r       <= wr_data[`GC_GC_TM];
         gate_single_pulse_mode_r <= wr_data[`GC_GC_SPM];
         gate_source_select_r     <= wr_data[`GC_GC_SS_HI:`GC_GC_SS_LO];
      end
   end

   // Interrupt enables
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         gate_event_irq_enable_r <= 1'b0;
         overflow_irq_enable_r   <= 1'b0;
         global_irq_enable_r     <= 1'b0;
         peripheral_irq_enable_r <= 1'b0;
      end else begin
         if (wr_ien) begin
            gate_event_irq_enable_r <= wr_data[`GC_IF_GATE];
            overflow_irq_enable_r   <= wr_data[`GC_IF_OVF];
         end
         if (wr_ictl) begin
            global_irq_enable_r     <= wr_data[`GC_IC_GIE];
            peripheral_irq_enable_r <= wr_data[`GC_IC_PERIPHERAL_IRQ_ENABLE];
         end
      end
   end

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic [3:0] async_in;
   logic [3:0] sync1_r;
   logic [3:0] sync2_r;
   logic       tclk_d_r;

   assign async_in = {comparator_b_output, comparator_a_output,
                      gate_pin, timer_clock};

   // Two stages for every pin-side input; only sync2 is looked at
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         sync1_r  <= 4'h0;
         sync2_r  <= 4'h0;
         tclk_d_r <= 1'b0;
      end else begin
         sync1_r  <= async_in;
         sync2_r  <= sync1_r;
         tclk_d_r <= sync2_r[0];
      end
   end

   // ----------------------------------------------------------------
   // Gate path: source, polarity, toggle, single pulse
   // ----------------------------------------------------------------
   logic   gate_src;
   logic   gate_pol_sig;
   logic   pol_d_r;
   logic   toggle_r;
   logic   gate_t;
   logic   gate_t_d_r;
   logic   t_rise;
   logic   t_fall;
   gc_sp_e sp_state_r;
   logic   gate_acquire_go_r;
   logic   go_done;
   logic   gate_level_r;
   logic   gate_level_d_r;

   // Source pick; the wrap pulse is already on this clock
   always_comb begin
      case (gate_source_select_r)
         2'h0:    gate_src = sync2_r[1];
         2'h1:    gate_src = byte_timer_wrap_pulse;
         2'h2:    gate_src = sync2_r[2];
         2'h3:    gate_src = sync2_r[3];
         default: gate_src = 1'b0;
      endcase
   end

   // Active level is high after this, whichever source is picked
   assign gate_pol_sig = gate_polarity_r ? gate_src : ~gate_src;

   // Toggle stage flips on each active rise; off and cleared otherwise
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         pol_d_r  <= 1'b0;
         toggle_r <= 1'b0;
      end else begin
         pol_d_r <= gate_pol_sig;
         if (!gate_toggle_mode_r || !timer_on_r) begin
            toggle_r <= 1'b0;
         end else if (gate_pol_sig && !pol_d_r) begin
            toggle_r <= ~toggle_r;
         end
      end
   end

   assign gate_t = gate_toggle_mode_r ? toggle_r : gate_pol_sig;
   assign t_rise = gate_t && !gate_t_d_r;
   assign t_fall = !gate_t && gate_t_d_r;

   // Single-pulse window; combined with toggle it spans a full cycle
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         gate_t_d_r <= 1'b0;
         sp_state_r <= SP_IDLE;
      end else begin
         gate_t_d_r <= gate_t;
         if (!gate_single_pulse_mode_r || !timer_on_r) begin
            sp_state_r <= SP_IDLE;
         end else begin
            case (sp_state_r)
               SP_IDLE: begin
                  if (gate_acquire_go_r) begin
                     sp_state_r <= SP_WAIT;
                  end
               end
               SP_WAIT: begin
                  if (!gate_acquire_go_r) begin
                     sp_state_r <= SP_IDLE;
                  end else if (t_rise) begin
                     sp_state_r <= SP_OPEN;
                  end
               end
               SP_OPEN: begin
                  if (t_fall) begin
                     sp_state_r <= SP_IDLE;
                  end
               end
               default: sp_state_r <= SP_IDLE;
            endcase
         end
      end
   end

   assign go_done = (sp_state_r == SP_OPEN) && t_fall
                    && gate_single_pulse_mode_r;

   // Go bit: software sets it, the trailing edge clears it; a write
   // in the same cycle wins so a fresh arm is never swallowed
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         gate_acquire_go_r <= 1'b0;
      end else if (wr_gcon) begin
         gate_acquire_go_r <= wr_data[`GC_GC_GO];
      end else if (go_done) begin
         gate_acquire_go_r <= 1'b0;
      end
   end

   // Gate level, kept whatever gate enable says
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         gate_level_r   <= 1'b0;
         gate_level_d_r <= 1'b0;
      end else begin
         gate_level_r   <= gate_single_pulse_mode_r ?
                           (sp_state_r == SP_OPEN) : gate_t;
         gate_level_d_r <= gate_level_r;
      end
   end

   // ----------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------
   gc_count_t count_r;
   logic      armed_r;
   logic      ext_mode;
   logic      run;
   logic      inc;
   logic      ovf_set;

   assign ext_mode = (clock_source_select_r == `GC_CS_EXT);

   // In sleep only the external counter with sync bypass set keeps going; its clock still passes the two sync stages
   assign run = timer_on_r
                && (!gate_enable_bit_r || gate_level_r)
                && (!sleep_mode || (sync_bypass_r && ext_mode));
   assign inc = run && armed_r && sync2_r[0] && !tclk_d_r;
   assign ovf_set = inc && (count_r == `GC_COUNT_TOP);

   // External clock must be seen low after enable or a count write,
   // so a clock already high does not give a spurious first count
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         armed_r <= 1'b0;
      end else if (!timer_on_r || wr_cnt) begin
         armed_r <= 1'b0;
      end else if (!ext_mode || !sync2_r[0]) begin
         armed_r <= 1'b1;
      end
   end

   // Count; a byte write wins over an increment in the same cycle
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         count_r <= `GC_RST_COUNT;
      end else if (wr_cntl) begin
         count_r[7:0] <= wr_data;
      end else if (wr_cnth) begin
         count_r[15:8] <= wr_data;
      end else if (inc) begin
         count_r <= count_r + 16'h0001;
      end
   end

   // ----------------------------------------------------------------
   // Flags, request and wake
   // ----------------------------------------------------------------
   logic gate_event_flag_r;
   logic overflow_flag_r;
   logic gev_set;

   assign gev_set = gate_level_d_r && !gate_level_r;

   // Sticky flags; a hardware set beats a software clear
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         gate_event_flag_r <= 1'b0;
         overflow_flag_r   <= 1'b0;
      end else begin
         if (gev_set) begin
            gate_event_flag_r <= 1'b1;
         end else if (wr_iflg) begin
            gate_event_flag_r <= wr_data[`GC_IF_GATE];
         end
         if (ovf_set) begin
            overflow_flag_r <= 1'b1;
         end else if (wr_iflg) begin
            overflow_flag_r <= wr_data[`GC_IF_OVF];
         end
      end
   end

   // Service request needs the global enable; wake does not
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         irq_req  <= 1'b0;
         wake_req <= 1'b0;
      end else begin
         irq_req  <= global_irq_enable_r && peripheral_irq_enable_r
                     && ((overflow_flag_r && overflow_irq_enable_r
                          && timer_on_r)
                         || (gate_event_flag_r
                             && gate_event_irq_enable_r));
         wake_req <= sleep_mode && overflow_flag_r && timer_on_r
                     && overflow_irq_enable_r && peripheral_irq_enable_r
                     && sync_bypass_r && ext_mode;
      end
   end

   // ----------------------------------------------------------------
   // Register read
   // ----------------------------------------------------------------

   // Data stand one cycle after the strobe only; unmapped reads zero
   always_ff @(posedge core_clk) begin
      if (!rst_b || !rd_stb) begin
         rd_data <= `GC_RST_BYTE;
      end else begin
         case (addr)
            `GC_OFF_TCON: rd_data <= {clock_source_select_r, prescale_r,
                                      1'b0, sync_bypass_r, 1'b0, timer_on_r};
            `GC_OFF_GCON: rd_data <= {gate_enable_bit_r, gate_polarity_r,
                                      gate_toggle_mode_r,
                                      gate_single_pulse_mode_r,
                                      gate_acquire_go_r, gate_level_r,
                                      gate_source_select_r};
            `GC_OFF_CNTL: rd_data <= count_r[7:0];
            `GC_OFF_CNTH: rd_data <= count_r[15:8];
            `GC_OFF_IFLG: rd_data <= {gate_event_flag_r, 6'h00,
                                      overflow_flag_r};
            `GC_OFF_IEN:  rd_data <= {gate_event_irq_enable_r, 6'h00,
                                      overflow_irq_enable_r};
            `GC_OFF_ICTL: rd_data <= {global_irq_enable_r,
                                      peripheral_irq_enable_r, 6'h00};
            default:      rd_data <= `GC_RST_BYTE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   a_count_holds: assert property (!inc && !wr_cnt |=> $stable(count_r))
      else $error("count moved without an increment");
   a_count_steps: assert property (inc && !wr_cnt |=>
                                   count_r == $past(count_r) + 16'h0001)
      else $error("count did not step by one");
   a_gate_holds_count: assert property (gate_enable_bit_r && !gate_level_r
                                        |-> !inc)
      else $error("counted with gate inactive");
   a_wrap_sets_flag: assert property (ovf_set |=> overflow_flag_r
                                      && count_r == 16'h0000)
      else $error("wrap did not set overflow flag");
   a_gate_fall_flag: assert property (gev_set |=> gate_event_flag_r)
      else $error("gate fall did not set event flag");
   a_toggle_cleared: assert property (!gate_toggle_mode_r |=> !toggle_r)
      else $error("toggle flip-flop not held clear");
   a_go_self_clear: assert property (go_done && !wr_gcon |=>
                                     !gate_acquire_go_r ##1
                                     sp_state_r == SP_IDLE)
      else $error("go not cleared at trailing edge");
   a_ovf_irq_gated: assert property (overflow_flag_r && overflow_irq_enable_r
                                     && timer_on_r && peripheral_irq_enable_r
                                     && global_irq_enable_r |=> irq_req)
      else $error("overflow request missing");
   a_irq_needs_gie: assert property (!global_irq_enable_r |=> !irq_req)
      else $error("request without global enable");
   a_off_no_count: assert property (!timer_on_r |-> !inc ##1 !toggle_r)
      else $error("counted while timer off");
   a_level_readback: assert property (rd_stb && addr == `GC_OFF_GCON |=>
                                      rd_data[`GC_GC_GVAL] == $past(gate_level_r))
      else $error("gate level read back wrong");

   c_wrap:        cover property (ovf_set);
   c_single_shot: cover property (go_done && gate_toggle_mode_r);
   c_gate_event:  cover property (gev_set && !gate_enable_bit_r);
   c_wake:        cover property (wake_req);

endmodule

`default_nettype wire

// [verif/gc_src_model.sv]
// Far-side sources: timer clock bursts and byte-timer wrap pulses.
// Assumes requests from the bench on core_clk rising edges.
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Source model
// ----------------------------------------
module gc_src_model (
   input  wire logic core_clk,
   input  wire logic clk_req,
   input  wire logic wrap_req,
   output logic      timer_clock,
   output logic      byte_timer_wrap_pulse
);
   logic [2:0] phase_r = 3'h0;
   logic       wrap_q_r = 1'b0;
   logic       pulse_r = 1'b0;
   // Clock stands low between bursts, so a low level precedes each first rise
   always_ff @(posedge core_clk) begin
      if (clk_req || phase_r != 3'h0) begin
         phase_r <= phase_r + 3'h1;
      end
   end
   assign timer_clock = phase_r[2]; // Four cycles high, four low
   // One low-to-high pulse per request, as at a byte-timer wrap
   always_ff @(posedge core_clk) begin
      wrap_q_r <= wrap_req;
      pulse_r  <= wrap_req && !wrap_q_r;
   end
   assign byte_timer_wrap_pulse = pulse_r;
endmodule
`default_nettype wire

// [verif/gc_gated_counter_tb_top.sv]
// Self-checking bench of the gated counter.
// Assumes the source model on the far side; gate levels driven here.
`include "gc_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module gc_gated_counter_tb_top import gc_pkg::*; ;
   logic [`GC_AW-1:0] addr;
   logic [`GC_DW-1:0] wr_data, rd_data, v;
   logic              core_clk, rst_b, wr_stb, rd_stb, timer_clock, gate_pin, wrap_pulse, comp_a;
   logic              comp_b, sleep_mode, irq_req, wake_req, clk_req, wrap_req;
   gc_count_t         exp_cnt, got;
   int                num_errors, checks_done;
   gc_gated_counter gc_gated_counter_i (.core_clk(core_clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .timer_clock(timer_clock), .gate_pin(gate_pin),
      .byte_timer_wrap_pulse(wrap_pulse), .comparator_a_output(comp_a), .comparator_b_output(comp_b),
      .sleep_mode(sleep_mode), .irq_req(irq_req), .wake_req(wake_req));
   gc_src_model gc_src_model_i (.core_clk(core_clk), .clk_req(clk_req), .wrap_req(wrap_req),
      .timer_clock(timer_clock), .byte_timer_wrap_pulse(wrap_pulse));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge core_clk);
      addr    <= a;
      wr_data <= d;
      wr_stb  <= 1'b1;
      @(posedge core_clk);
      wr_stb  <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge core_clk);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge core_clk);
      rd_stb <= 1'b0;
      @(negedge core_clk);
      d = rd_data;
      @(posedge core_clk); // Leaves the caller on a rising edge for its next drive
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // Gate pin change, then time for two sync stages, toggle and level flops
   task automatic gate_to(input logic l);
      gate_pin <= l;
      wait_n(8);
   endtask
   // Each burst period is eight cycles; the wait lets synchronisers settle
   task automatic tick(input int n);
      @(posedge core_clk);
      clk_req <= 1'b1;
      repeat (8 * n) @(posedge core_clk);
      clk_req <= 1'b0;
      wait_n(12);
   endtask
   task automatic cnt_chk(input string what);
      rd(`GC_OFF_CNTL, v);
      got[7:0] = v;
      rd(`GC_OFF_CNTH, v);
      got[15:8] = v;
      chk(what, exp_cnt, got);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_off();
      tick(2);
      for (int a = 0; a < 8; a++) begin
         rd(3'(a), v);
         // Gate low with polarity 0 is an active gate, so the level bit reads set
         chk("reg after reset", (a == 1) ? 16'h0004 : 16'h0000, 16'(v));
      end
   endtask
   task automatic t_gate();
      wr(`GC_OFF_TCON, 8'h01);
      wr(`GC_OFF_GCON, 8'h00);
      tick(2);
      exp_cnt += 16'h2;
      cnt_chk("count free");
      for (int s = 0; s < 4; s++) begin
         for (int p = 0; p < 2; p++) begin
            for (int lv = 0; lv < 2; lv++) begin
               gate_pin <= 1'(lv);
               comp_a   <= 1'(lv);
               comp_b   <= 1'(lv);
               wr(`GC_OFF_GCON, {1'b1, 1'(p), 4'h0, 2'(s)});
               wait_n(8);
               tick(2);
               if (((s == 1) ? 0 : lv) == p) exp_cnt += 16'h2;
               cnt_chk("count gated");
            end
         end
      end
   endtask
   task automatic t_single();
      gate_pin <= 1'b0;
      wr(`GC_OFF_GCON, 8'hd0);
      wr(`GC_OFF_GCON, 8'hd8);
      wait_n(8);
      tick(2);
      cnt_chk("count armed");
      gate_pin <= 1'b1;
      wait_n(8);
      tick(2);
      exp_cnt += 16'h2;
      cnt_chk("count window");
      gate_pin <= 1'b0;
      wait_n(8);
      rd(`GC_OFF_GCON, v);
      chk("go after pulse", 16'h00d0, 16'(v));
      gate_pin <= 1'b1;
      wait_n(8);
      tick(2);
      cnt_chk("count after pulse");
      wr(`GC_OFF_GCON, 8'h00);
   endtask
   task automatic t_toggle();
      gate_to(1'b0);
      wr(`GC_OFF_GCON, 8'hc0);
      wr(`GC_OFF_GCON, 8'he0);
      gate_to(1'b1);
      gate_to(1'b0);
      tick(2);
      exp_cnt += 16'h2;
      cnt_chk("toggle low half");
      gate_to(1'b1);
      tick(2);
      cnt_chk("toggle closed");
      wr(`GC_OFF_GCON, 8'hf0);
      wr(`GC_OFF_GCON, 8'hf8);
      gate_to(1'b0);
      gate_to(1'b1);
      gate_to(1'b0);
      tick(2);
      exp_cnt += 16'h2;
      cnt_chk("full cycle");
      gate_to(1'b1);
      rd(`GC_OFF_GCON, v);
      chk("go after cycle", 16'h00f0, 16'(v));
      wr(`GC_OFF_GCON, 8'h00);
   endtask
   task automatic t_event();
      wr(`GC_OFF_GCON, 8'h40);
      wait_n(8);
      wr(`GC_OFF_IFLG, 8'h00);
      rd(`GC_OFF_GCON, v);
      chk("level high", 16'h0044, 16'(v));
      gate_pin <= 1'b0;
      wait_n(8);
      rd(`GC_OFF_GCON, v);
      chk("level low", 16'h0040, 16'(v));
      rd(`GC_OFF_IFLG, v);
      chk("event flag", 16'h0080, 16'(v));
      wr(`GC_OFF_IFLG, 8'h00);
      wr(`GC_OFF_IEN, 8'h80);
      wr(`GC_OFF_ICTL, 8'hc0);
      wr(`GC_OFF_GCON, 8'h41);
      wrap_req <= 1'b1;
      wait_n(2);
      wrap_req <= 1'b0;
      wait_n(8);
      rd(`GC_OFF_IFLG, v);
      chk("wrap event", 16'h0080, 16'(v));
      chk("event request", 16'h1, 16'(irq_req));
      wr(`GC_OFF_IFLG, 8'h00);
      wr(`GC_OFF_ICTL, 8'h00);
      wr(`GC_OFF_GCON, 8'h00);
   endtask
   task automatic t_ovf();
      wr(`GC_OFF_TCON, 8'h00);
      wr(`GC_OFF_CNTL, 8'hff);
      wr(`GC_OFF_CNTH, 8'hff);
      exp_cnt = 16'h0000;
      wr(`GC_OFF_IEN, 8'h01);
      wr(`GC_OFF_ICTL, 8'h40);
      sleep_mode <= 1'b1;
      wr(`GC_OFF_TCON, 8'h85);
      tick(1);
      cnt_chk("count wrap");
      rd(`GC_OFF_IFLG, v);
      chk("overflow flag", 16'h0001, 16'(v));
      chk("wake", 16'h1, 16'(wake_req));
      chk("request no global", 16'h0, 16'(irq_req));
      wr(`GC_OFF_ICTL, 8'hc0);
      wait_n(3);
      chk("request", 16'h1, 16'(irq_req));
      wr(`GC_OFF_IFLG, 8'h00);
      wait_n(3);
      chk("request cleared", 16'h0, 16'(irq_req));
      chk("wake cleared", 16'h0, 16'(wake_req));
   endtask
   task automatic results();
      if (num_errors == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Clock, main sequence and watchdog
   initial begin
      core_clk = 1'b0;
      forever #(`GC_CLK_PERIOD_NS / 2) core_clk = ~core_clk;
   end
   initial begin
      {rst_b, wr_stb, rd_stb, gate_pin, comp_a, comp_b, sleep_mode, clk_req, wrap_req} = '0;
      addr = '0;
      wr_data = '0;
      exp_cnt = '0;
      num_errors = 0;
      checks_done = 0;
      repeat (16) @(posedge core_clk);
      rst_b <= 1'b1;
      t_off();
      t_gate();
      t_single();
      t_toggle();
      t_event();
      t_ovf();
      results();
   end
   initial begin
      repeat (30000) @(posedge core_clk);
      num_errors++;
      results();
   end
endmodule
`default_nettype wire
